// >>> include/isr_pkg.sv
package isr_pkg;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned WORDS      = 32;
  // Frame header fields
  localparam int unsigned HDR_WRITE_BIT = 15;
  localparam int unsigned HDR_ZERO_BIT  = 14;
  localparam int unsigned ADDR_MSB      = 13;
  localparam int unsigned ADDR_LSB      = 8;
  // Output word fields
  localparam int unsigned FRESH_BIT = 15;
  localparam int unsigned FAULT_BIT = 14;
  // Register byte addresses (even byte of each pair)
  localparam logic [5:0] A_ENDURANCE = 6'h00;
  localparam logic [5:0] A_SUPPLY    = 6'h02;
  localparam logic [5:0] A_XACC      = 6'h04;
  localparam logic [5:0] A_YACC      = 6'h06;
  localparam logic [5:0] A_AUX       = 6'h08;
  localparam logic [5:0] A_TEMP      = 6'h0A;
  localparam logic [5:0] A_XPEAK     = 6'h0C;
  localparam logic [5:0] A_YPEAK     = 6'h0E;
  localparam logic [5:0] A_XOFS      = 6'h10;
  localparam logic [5:0] A_YOFS      = 6'h12;
  localparam logic [5:0] A_XGAIN     = 6'h14;
  localparam logic [5:0] A_YGAIN     = 6'h16;
  localparam logic [5:0] A_XYOUT     = 6'h18;
  localparam logic [5:0] A_XYPEAK    = 6'h1A;
  localparam logic [5:0] A_ALM1      = 6'h20;
  localparam logic [5:0] A_ALM2      = 6'h22;
  localparam logic [5:0] A_ALMCTL    = 6'h28;
  localparam logic [5:0] A_CAPPTR    = 6'h2A;
  localparam logic [5:0] A_AUXDAC    = 6'h30;
  localparam logic [5:0] A_PINCTL    = 6'h32;
  localparam logic [5:0] A_MISC      = 6'h34;
  localparam logic [5:0] A_PERIOD    = 6'h36;
  localparam logic [5:0] A_CAPCFG    = 6'h38;
  localparam logic [5:0] A_SLEEP     = 6'h3A;
  localparam logic [5:0] A_STATUS    = 6'h3C;
  localparam logic [5:0] A_ACTION    = 6'h3E;
  // Reset values
  localparam logic [15:0] GAIN_RESET   = 16'h0800;
  localparam logic [15:0] PERIOD_RESET = 16'h0001;
  // Bits of misc_control and global_action
  localparam int unsigned MISC_SELFTEST_BIT = 8;
  localparam int unsigned CMD_SAVE_BIT      = 3;
  localparam int unsigned CMD_PEAKCLR_BIT   = 5;
  localparam int unsigned CMD_REBOOT_BIT    = 7;
  // fresh_sample_flag slots
  localparam int unsigned NFRESH = 9;
  localparam int unsigned F_SUP = 0, F_X = 1, F_Y = 2, F_AUX = 3, F_TMP = 4;
  localparam int unsigned F_XP = 5, F_YP = 6, F_XY = 7, F_XYP = 8;

  typedef enum logic [1:0] {SEQ_BOOT, SEQ_SAVE, SEQ_IDLE} isr_seq_e;

  typedef struct packed {
    logic        valid;
    logic [13:0] x;
    logic [13:0] y;
    logic [11:0] supply;
    logic [11:0] aux;
    logic [11:0] temp;
  } isr_sample_s;

  function automatic logic isr_is_rw(input logic [5:0] a);
    return a >= A_XOFS && a <= A_YGAIN + 6'h01 || a >= A_ALM1 && a <= A_ALM2 + 6'h01
      || a >= A_ALMCTL && a <= A_SLEEP + 6'h01;
  endfunction : isr_is_rw

  function automatic logic isr_is_nonvol(input logic [5:0] a);
    return isr_is_rw(a) && a != A_CAPPTR && a != A_CAPPTR + 6'h01 && a < A_AUXDAC
      || a >= A_MISC && a <= A_CAPCFG + 6'h01;
  endfunction : isr_is_nonvol

  function automatic logic [15:0] isr_default(input logic [4:0] idx);
    if ({idx, 1'b0} == A_XGAIN || {idx, 1'b0} == A_YGAIN) return GAIN_RESET;
    if ({idx, 1'b0} == A_PERIOD) return PERIOD_RESET;
    return 16'h0000;
  endfunction : isr_default

  function automatic logic [13:0] isr_abs14(input logic [13:0] v);
    return v[13] ? 14'(-v) : v;
  endfunction : isr_abs14

  function automatic logic [15:0] isr_word(input logic nd, input logic ea,
                                           input logic [13:0] d);
    return {nd, ea, d};
  endfunction : isr_word
endpackage : isr_pkg

// >>> rtl/isr_register_access.sv
`timescale 1ns/1ns
// What this block does
// - Write frame: 1, 0, six address bits, eight data bits into that byte.
// - Serial input bits are sampled on the rising serial clock edge.
// - Read frame: two zeros, six address bits; last eight bits ignored.
// - Either byte address of a register reads back all sixteen bits.
// - Read data is shifted out in the frame after the request.
// - First output bit at select fall, later bits on falling clock edges.
// - A new request may ride in the frame that returns the previous answer.
// - Peaks hold the X, Y sample of largest magnitude (signed) and largest XY (unsigned) until cleared.
// - Output registers update every sample regardless of reads.
// - Upper byte is shifted out before lower byte.
// - Output word: bit 15 fresh flag, bit 14 fault flag, data below.
// - Fresh flag sets on new sample, clears after that register is read.
// - Fault flag follows any active system error or alarm.
// - Outputs are 12 or 14 bits; bits 13:12 unused for 12-bit.
// - Axes and X, Y peaks signed 14-bit; supply, aux, temp 12-bit; XY and XY peak unsigned.
// - XY output is the root of the sum of squared X and Y.
// - Control registers live in working storage; all but capture pointer, aux DAC, pin control and sleep load from flash at start.
// - Flash is written only on the flash update command.
// - A readable counter tracks flash write cycles.
// - Self-test request bit clears itself when self-test completes.
// - With select high, output floats and clock and input are ignored.
// - Every frame is sixteen serial clocks with select low.
// - Writing 1 to command bit 5 zeroes all peak registers; a sample arriving in that cycle is loaded instead.
module isr_register_access
(
  input  wire logic                 i_clk,           // Core clock, 250 MHz
  input  wire logic                 i_rst,           // Sync reset, active high
  input  wire logic                 i_sclk,          // Serial clock
  input  wire logic                 i_cs_n,          // Chip select, active low
  input  wire logic                 i_din,           // Serial data in
  output logic                      o_dout,          // Serial data out
  output logic                      o_dout_oe,       // Serial out drive enable
  input  wire isr_pkg::isr_sample_s i_sample,        // Converter samples
  input  wire logic                 i_fault_alarm,   // Error or alarm active
  input  wire logic [15:0]          i_status,        // System condition bits
  input  wire logic                 i_selftest_done, // Self-test finished pulse
  output logic                      o_selftest_req,  // Self-test request level
  output logic      [15:0]          o_cmd_pulse,     // Command bits, one cycle
  output logic                      o_busy           // Flash copy in progress
);
  import isr_pkg::*;

  // Serial side
  logic [15:0] rx_word;
  logic        frame_tgl;
  logic [15:0] tx_hold_reg;

  // Crossing of the frame toggle
  logic        tgl_meta_reg;
  logic        tgl_sync_reg;
  logic        tgl_seen_reg;
  logic        accept;

  // Frame decode
  logic        is_write;
  logic        is_read;
  logic [5:0]  fr_addr;
  logic [7:0]  fr_data;
  logic        rd_pend_reg;
  logic [5:0]  rd_addr_reg;

  // Copy sequencer
  isr_seq_e    seq_reg;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_d_reg;
  logic        copy_vld_reg;
  logic        copy_boot_reg;
  logic [15:0] endurance_reg;

  // Storage ports
  logic [1:0]  work_we;
  logic [4:0]  work_waddr;
  logic [15:0] work_wdata;
  logic [4:0]  work_raddr;
  logic [15:0] work_rdata;
  logic [1:0]  flash_we;
  logic [15:0] flash_rdata;

  // Measurements
  logic [13:0] x_reg;
  logic [13:0] y_reg;
  logic [11:0] supply_reg;
  logic [11:0] aux_reg;
  logic [11:0] temp_reg;
  logic [13:0] xy_reg;
  logic [13:0] xpk_reg;
  logic [13:0] ypk_reg;
  logic [13:0] xypk_reg;
  logic [13:0] xy_now;
  logic [13:0] ax;
  logic [13:0] ay;
  logic [13:0] xpk_base;
  logic [13:0] ypk_base;
  logic [13:0] xypk_base;
  logic        peak_clr;
  logic [NFRESH-1:0] fresh_reg;
  logic [NFRESH-1:0] fresh_clr;
  logic [15:0] rd_word;

  function automatic logic [13:0] isqrt(input logic [27:0] v);
    logic [13:0] root;
    logic [13:0] cand;
    root = 14'h0000;
    for (int b = 13; b >= 0; b--)
    begin
      cand = root | (14'h0001 << b);
      if (28'(cand) * 28'(cand) <= v)
        root = cand;
    end
    return root;
  endfunction : isqrt

  isr_spi_link u_link
  (
    .i_rst       (i_rst),
    .i_sclk      (i_sclk),
    .i_cs_n      (i_cs_n),
    .i_din       (i_din),
    .o_dout      (o_dout),
    .o_dout_oe   (o_dout_oe),
    .i_tx_word   (tx_hold_reg),
    .o_rx_word   (rx_word),
    .o_frame_tgl (frame_tgl)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
    end
    else
    begin
      tgl_meta_reg <= frame_tgl;
      tgl_sync_reg <= tgl_meta_reg;
    end
  end

  // Frames wait while a flash copy owns the storage ports
  assign accept = (tgl_sync_reg ^ tgl_seen_reg) && seq_reg == SEQ_IDLE && !copy_vld_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      tgl_seen_reg <= 1'b0;
    else if (accept)
      tgl_seen_reg <= tgl_sync_reg;
  end

  // Received word stays put until the next frame completes
  assign is_write = rx_word[HDR_WRITE_BIT] && !rx_word[HDR_ZERO_BIT];
  assign is_read  = !rx_word[HDR_WRITE_BIT] && !rx_word[HDR_ZERO_BIT];
  assign fr_addr  = rx_word[ADDR_MSB:ADDR_LSB];
  assign fr_data  = rx_word[7:0];

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 6'h00;
    end
    else
    begin
      rd_pend_reg <= accept && is_read;
      if (accept && is_read)
        rd_addr_reg <= fr_addr;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_cmd_pulse <= 16'h0000;
    else if (accept && is_write && fr_addr[5:1] == A_ACTION[5:1])
      o_cmd_pulse <= fr_addr[0] ? {fr_data, 8'h00} : {8'h00, fr_data};
    else
      o_cmd_pulse <= 16'h0000;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      seq_reg       <= SEQ_BOOT;
      cnt_reg       <= 5'h00;
      cnt_d_reg     <= 5'h00;
      copy_vld_reg  <= 1'b0;
      copy_boot_reg <= 1'b0;
    end
    else
    begin
      cnt_d_reg     <= cnt_reg;
      copy_vld_reg  <= seq_reg != SEQ_IDLE;
      copy_boot_reg <= seq_reg == SEQ_BOOT;
      unique case (seq_reg)
        SEQ_BOOT, SEQ_SAVE:
        begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'(WORDS - 1))
            seq_reg <= SEQ_IDLE;
        end
        SEQ_IDLE:
        begin
          cnt_reg <= 5'h00;
          if (o_cmd_pulse[CMD_REBOOT_BIT])
            seq_reg <= SEQ_BOOT;
          else if (o_cmd_pulse[CMD_SAVE_BIT])
            seq_reg <= SEQ_SAVE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      endurance_reg <= 16'h0000;
    else if (seq_reg == SEQ_IDLE && o_cmd_pulse[CMD_SAVE_BIT] && !o_cmd_pulse[CMD_REBOOT_BIT])
      endurance_reg <= endurance_reg + 16'h0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_busy <= 1'b1;
    else
      o_busy <= seq_reg != SEQ_IDLE || copy_vld_reg;
  end

  always_comb
  begin
    work_we    = 2'b00;
    work_waddr = fr_addr[5:1];
    work_wdata = {fr_data, fr_data};
    flash_we   = 2'b00;
    if (copy_vld_reg && isr_is_nonvol({cnt_d_reg, 1'b0}))
    begin
      work_waddr = cnt_d_reg;
      work_wdata = flash_rdata;
      work_we    = copy_boot_reg ? 2'b11 : 2'b00;
      flash_we   = copy_boot_reg ? 2'b00 : 2'b11;
    end
    else if (accept && is_write && isr_is_rw(fr_addr))
      work_we = fr_addr[0] ? 2'b10 : 2'b01;
    work_raddr = seq_reg == SEQ_SAVE ? cnt_reg : fr_addr[5:1];
  end

  isr_word_ram u_work
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_we    (work_we),
    .i_waddr (work_waddr),
    .i_wdata (work_wdata),
    .i_raddr (work_raddr),
    .o_rdata (work_rdata)
  );

  isr_word_ram u_flash
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_we    (flash_we),
    .i_waddr (cnt_d_reg),
    .i_wdata (work_rdata),
    .i_raddr (cnt_reg),
    .o_rdata (flash_rdata)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_selftest_req <= 1'b0;
    else if (accept && is_write && fr_addr == A_MISC + 6'h01 && fr_data[MISC_SELFTEST_BIT - 8])
      o_selftest_req <= 1'b1;
    else if (i_selftest_done)
      o_selftest_req <= 1'b0;
  end

  // Sample path; deep combinational root traded against latency
  assign xy_now = isqrt(28'(isr_abs14(i_sample.x)) * 28'(isr_abs14(i_sample.x))
                      + 28'(isr_abs14(i_sample.y)) * 28'(isr_abs14(i_sample.y)));

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      x_reg      <= 14'h0000;
      y_reg      <= 14'h0000;
      supply_reg <= 12'h000;
      aux_reg    <= 12'h000;
      temp_reg   <= 12'h000;
      xy_reg     <= 14'h0000;
    end
    else if (i_sample.valid)
    begin
      x_reg      <= i_sample.x;
      y_reg      <= i_sample.y;
      supply_reg <= i_sample.supply;
      aux_reg    <= i_sample.aux;
      temp_reg   <= i_sample.temp;
      xy_reg     <= xy_now;
    end
  end

  // Clear and a larger sample together keep the sample
  assign peak_clr  = o_cmd_pulse[CMD_PEAKCLR_BIT];
  assign xpk_base  = peak_clr ? 14'h0000 : xpk_reg;
  assign ypk_base  = peak_clr ? 14'h0000 : ypk_reg;
  assign xypk_base = peak_clr ? 14'h0000 : xypk_reg;
  assign ax        = isr_abs14(i_sample.x);
  assign ay        = isr_abs14(i_sample.y);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      xpk_reg  <= 14'h0000;
      ypk_reg  <= 14'h0000;
      xypk_reg <= 14'h0000;
    end
    else
    begin
      xpk_reg  <= i_sample.valid && ax > isr_abs14(xpk_base) ? i_sample.x : xpk_base;
      ypk_reg  <= i_sample.valid && ay > isr_abs14(ypk_base) ? i_sample.y : ypk_base;
      xypk_reg <= i_sample.valid && xy_now > xypk_base ? xy_now : xypk_base;
    end
  end

  always_comb
  begin
    fresh_clr = '0;
    rd_word   = 16'h0000;
    unique case ({rd_addr_reg[5:1], 1'b0})
      A_ENDURANCE: rd_word = endurance_reg;
      A_SUPPLY:
      begin
        rd_word = isr_word(fresh_reg[F_SUP], i_fault_alarm, {2'b00, supply_reg});
        fresh_clr[F_SUP] = 1'b1;
      end
      A_XACC:
      begin
        rd_word = isr_word(fresh_reg[F_X], i_fault_alarm, x_reg);
        fresh_clr[F_X] = 1'b1;
      end
      A_YACC:
      begin
        rd_word = isr_word(fresh_reg[F_Y], i_fault_alarm, y_reg);
        fresh_clr[F_Y] = 1'b1;
      end
      A_AUX:
      begin
        rd_word = isr_word(fresh_reg[F_AUX], i_fault_alarm, {2'b00, aux_reg});
        fresh_clr[F_AUX] = 1'b1;
      end
      A_TEMP:
      begin
        rd_word = isr_word(fresh_reg[F_TMP], i_fault_alarm, {2'b00, temp_reg});
        fresh_clr[F_TMP] = 1'b1;
      end
      A_XPEAK:
      begin
        rd_word = isr_word(fresh_reg[F_XP], i_fault_alarm, xpk_reg);
        fresh_clr[F_XP] = 1'b1;
      end
      A_YPEAK:
      begin
        rd_word = isr_word(fresh_reg[F_YP], i_fault_alarm, ypk_reg);
        fresh_clr[F_YP] = 1'b1;
      end
      A_XYOUT:
      begin
        rd_word = isr_word(fresh_reg[F_XY], i_fault_alarm, xy_reg);
        fresh_clr[F_XY] = 1'b1;
      end
      A_XYPEAK:
      begin
        rd_word = isr_word(fresh_reg[F_XYP], i_fault_alarm, xypk_reg);
        fresh_clr[F_XYP] = 1'b1;
      end
      A_MISC:
      begin
        rd_word = work_rdata;
        rd_word[MISC_SELFTEST_BIT] = o_selftest_req;
      end
      A_STATUS: rd_word = i_status;
      default:
        // Write-only, event-record and unused spaces read as zero
        rd_word = isr_is_rw(rd_addr_reg) && rd_addr_reg[5:1] != A_SLEEP[5:1]
                  ? work_rdata : 16'h0000;
    endcase
    if (!rd_pend_reg)
      fresh_clr = '0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      fresh_reg <= '0;
    else
      fresh_reg <= (fresh_reg & ~fresh_clr) | {NFRESH{i_sample.valid}};
  end

  // Answer is loaded between frames; select must stay high long enough
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      tx_hold_reg <= 16'h0000;
    else if (rd_pend_reg)
      tx_hold_reg <= rd_word;
    else if (accept && !is_read)
      tx_hold_reg <= 16'h0000;
  end
endmodule : isr_register_access

// >>> rtl/isr_spi_link.sv
`timescale 1ns/1ns
module isr_spi_link
(
  input  wire logic        i_rst,     // Core reset, clears the toggle
  input  wire logic        i_sclk,    // Serial clock, idles high
  input  wire logic        i_cs_n,    // Chip select, active low
  input  wire logic        i_din,     // Serial data in
  output logic             o_dout,    // Serial data out
  output logic             o_dout_oe, // Drive enable for serial out
  input  wire logic [15:0] i_tx_word, // Answer word, stable across frame
  output logic      [15:0] o_rx_word, // Last complete frame
  output logic             o_frame_tgl // Flips once per complete frame
);
  import isr_pkg::*;

  logic [3:0]  bit_cnt_reg;
  logic [14:0] rx_shift_reg;
  logic [14:0] tx_shift_reg;
  logic        started_reg;

  // Chip select high holds everything idle; sclk edges are ignored
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      bit_cnt_reg  <= 4'h0;
      rx_shift_reg <= 15'h0000;
    end
    else
    begin
      bit_cnt_reg  <= bit_cnt_reg + 4'h1;
      rx_shift_reg <= {rx_shift_reg[13:0], i_din};
    end
  end

  always_ff @(posedge i_sclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rx_word   <= 16'h0000;
      o_frame_tgl <= 1'b0;
    end
    else if (!i_cs_n && bit_cnt_reg == 4'(FRAME_BITS - 1))
    begin
      o_rx_word   <= {rx_shift_reg, i_din};
      o_frame_tgl <= ~o_frame_tgl;
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      started_reg  <= 1'b0;
      tx_shift_reg <= 15'h0000;
    end
    else if (!started_reg)
    begin
      // First fall keeps the top bit on the pin; the master samples it on the next rise
      if (bit_cnt_reg != 4'h0)
      begin
        started_reg  <= 1'b1;
        tx_shift_reg <= i_tx_word[14:0];
      end
    end
    else
      tx_shift_reg <= {tx_shift_reg[13:0], 1'b0};
  end

  // Top bit leads as soon as select falls, before any clock edge
  assign o_dout    = started_reg ? tx_shift_reg[14] : i_tx_word[15];
  assign o_dout_oe = ~i_cs_n;
endmodule : isr_spi_link

// >>> rtl/isr_word_ram.sv
`timescale 1ns/1ns
module isr_word_ram
(
  input  wire logic        i_clk,   // Core clock
  input  wire logic        i_rst,   // Sync reset, loads defaults
  input  wire logic [1:0]  i_we,    // Byte write enables
  input  wire logic [4:0]  i_waddr, // Write word index
  input  wire logic [15:0] i_wdata, // Write data
  input  wire logic [4:0]  i_raddr, // Read word index
  output logic      [15:0] o_rdata  // Registered read data
);
  import isr_pkg::*;

  logic [15:0] mem_reg [WORDS];

  always_ff @(posedge i_clk)
  begin
    for (int i = 0; i < WORDS; i++)
    begin
      if (i_rst)
        mem_reg[i] <= isr_default(5'(i));
      else if (i_waddr == 5'(i))
      begin
        if (i_we[0]) mem_reg[i][7:0] <= i_wdata[7:0];
        if (i_we[1]) mem_reg[i][15:8] <= i_wdata[15:8];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else
      o_rdata <= mem_reg[i_raddr];
  end
endmodule : isr_word_ram

// >>> verification/isr_register_access_props.sv
`timescale 1ns/1ns
module isr_register_access_props
(
  input wire logic        i_clk,           // Core clock
  input wire logic        i_rst,           // Sync reset
  input wire logic        i_sclk,          // Serial clock
  input wire logic        i_cs_n,          // Chip select
  input wire logic        o_dout_oe,       // Serial out enable
  input wire logic        i_selftest_done, // Self-test end pulse
  input wire logic        o_selftest_req,  // Self-test level
  input wire logic [15:0] o_cmd_pulse,     // Command pulses
  input wire logic        o_busy           // Copy in progress
);
  import isr_pkg::*;
  a_oe_tracks_select: assert property (@(posedge i_clk) disable iff (i_rst)
    o_dout_oe == !i_cs_n) else $error("drive enable differs from select");
  a_oe_in_frame: assert property (@(posedge i_sclk) disable iff (i_rst)
    !i_cs_n |-> o_dout_oe) else $error("output not driven inside frame");
  a_boot_copy_bounded: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> o_busy [*8] ##[1:40] !o_busy) else $error("boot copy length wrong");
  a_cmd_single_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
    |o_cmd_pulse |=> o_cmd_pulse == 16'h0000) else $error("command pulse too long");
  a_cmd_after_frame: assert property (@(posedge i_clk) disable iff (i_rst)
    |o_cmd_pulse |-> i_cs_n) else $error("command taken inside a frame");
  a_save_sets_busy: assert property (@(posedge i_clk) disable iff (i_rst)
    o_cmd_pulse[CMD_SAVE_BIT] |-> ##[0:3] o_busy ##[1:40] !o_busy)
    else $error("flash save copy missing or too long");
  a_selftest_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    i_selftest_done |=> !o_selftest_req) else $error("self-test request stuck");
  a_selftest_idle_set: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_selftest_req) |-> !$past(o_busy)) else $error("request set while busy");
  c_save: cover property (@(posedge i_clk) o_cmd_pulse[CMD_SAVE_BIT]);
  c_selftest: cover property (@(posedge i_clk) $rose(o_selftest_req));
  c_boot_done: cover property (@(posedge i_clk) $fell(o_busy));
endmodule : isr_register_access_props

bind isr_register_access isr_register_access_props i_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_dout_oe(o_dout_oe), .i_selftest_done(i_selftest_done),
  .o_selftest_req(o_selftest_req), .o_cmd_pulse(o_cmd_pulse), .o_busy(o_busy));

// >>> verification/isr_register_access_tb.sv
`timescale 1ns/1ns
module isr_register_access_tb;
  import isr_pkg::*;
  logic        clk, rst, sclk, cs_n, din, dout, dout_oe, fault, st_done, st_req, busy;
  logic [15:0] status, cmd, cmd_seen, rx, p_exp, p_mask;
  logic        seen_clr;
  isr_sample_s smp;
  int          num_errors, checks_done, cycles;

  isr_register_access i_dut (.i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe), .i_sample(smp), .i_fault_alarm(fault),
    .i_status(status), .i_selftest_done(st_done), .o_selftest_req(st_req),
    .o_cmd_pulse(cmd), .o_busy(busy));
  isr_spi_master i_master (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout),
    .i_dout_oe(dout_oe));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    cmd_seen <= seen_clr ? cmd : (cmd_seen | cmd);
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] got, exp, input logic [15:0] mask = 16'hFFFF);
    checks_done++;
    if ((got & mask) !== (exp & mask))
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    if ((got & mask) !== (exp & mask))
      num_errors++;
  endtask : check

  function automatic logic [15:0] rd(input logic [5:0] a);
    return {2'b00, a, 8'hA5};
  endfunction : rd

  function automatic logic [15:0] wr(input logic [5:0] a, input logic [7:0] d);
    return {2'b10, a, d};
  endfunction : wr

  // Each frame returns what the previous one asked for
  task automatic frame(input logic [15:0] tx, exp, input logic [15:0] mask = 16'hFFFF);
    i_master.xfer(tx, 1'b1, rx);
    check(rx, p_exp, p_mask);
    p_exp = exp;
    p_mask = mask;
  endtask : frame

  task automatic idle;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 200);
    check({15'h0, busy}, 16'h0000);
  endtask : idle

  task automatic put_sample(input logic [13:0] x, y);
    @(posedge clk);
    smp <= '{1'b1, x, y, 12'h123, 12'h456, 12'h789};
    @(posedge clk);
    smp.valid <= 1'b0;
  endtask : put_sample

  task automatic t_defaults;
    frame(rd(A_XGAIN + 6'h01), 16'h0800);
    frame(rd(A_PERIOD), 16'h0001);
    frame(rd(A_ENDURANCE), 16'h0000);
    frame(rd(A_STATUS + 6'h01), status);
    frame(16'hFFFF, 16'h0000);
    $display("t_defaults done");
  endtask : t_defaults

  task automatic t_byte_write;
    frame(wr(A_XOFS, 8'h34), 16'h0000);
    frame(wr(A_XOFS + 6'h01, 8'h12), 16'h0000);
    frame(wr(A_STATUS, 8'hFF), 16'h0000);
    frame(rd(A_STATUS), status);
    i_master.xfer(wr(A_XOFS, 8'hEE), 1'b0, rx);
    frame(rd(A_XOFS + 6'h01), 16'h1234);
    frame(16'hFFFF, 16'h0000);
    $display("t_byte_write done");
  endtask : t_byte_write

  task automatic t_samples;
    @(posedge clk);
    fault <= 1'b1;
    put_sample(14'h0003, 14'h3FFC);
    frame(rd(A_XACC), 16'hC003);
    frame(rd(A_XACC), 16'h4003);
    frame(rd(A_XYOUT), 16'hC005);
    frame(rd(A_YPEAK), 16'hFFFC);
    frame(rd(A_SUPPLY), 16'hC123, 16'hCFFF);
    put_sample(14'h0001, 14'h3FFF);
    fault <= 1'b0;
    frame(rd(A_XPEAK), 16'h8003);
    frame(rd(A_XACC), 16'h8001);
    frame(rd(A_XYPEAK), 16'h8005);
    frame(rd(A_AUX), 16'h8456, 16'hCFFF);
    frame(rd(A_TEMP), 16'h8789, 16'hCFFF);
    frame(16'hFFFF, 16'h0000);
    $display("t_samples done");
  endtask : t_samples

  task automatic t_peak_clear;
    @(posedge clk);
    seen_clr <= 1'b1;
    @(posedge clk);
    seen_clr <= 1'b0;
    frame(wr(A_ACTION, 8'h20), 16'h0000);
    check(cmd_seen, 16'h0020);
    frame(rd(A_XPEAK), 16'h0000, 16'h7FFF);
    frame(rd(A_XYPEAK), 16'h0000, 16'h7FFF);
    frame(16'hFFFF, 16'h0000);
    $display("t_peak_clear done");
  endtask : t_peak_clear

  task automatic t_save_reload;
    @(posedge clk);
    seen_clr <= 1'b1;
    @(posedge clk);
    seen_clr <= 1'b0;
    frame(wr(A_ACTION, 8'h08), 16'h0000);
    idle();
    check(cmd_seen, 16'h0008);
    frame(rd(A_ENDURANCE), 16'h0001);
    frame(wr(A_XOFS, 8'h99), 16'h0000);
    frame(wr(A_ACTION, 8'h80), 16'h0000);
    idle();
    frame(rd(A_XOFS), 16'h1234);
    frame(16'hFFFF, 16'h0000);
    $display("t_save_reload done");
  endtask : t_save_reload

  task automatic t_selftest;
    frame(wr(A_MISC + 6'h01, 8'h01), 16'h0000);
    check({15'h0, st_req}, 16'h0001);
    @(posedge clk);
    st_done <= 1'b1;
    @(posedge clk);
    st_done <= 1'b0;
    @(posedge clk);
    check({15'h0, st_req}, 16'h0000);
    frame(rd(A_MISC), 16'h0000, 16'h0100);
    frame(16'hFFFF, 16'h0000);
    $display("t_selftest done");
  endtask : t_selftest

  initial
  begin
    rst = 1'b1;
    fault = 1'b0;
    st_done = 1'b0;
    status = 16'hC3A5;
    smp = '0;
    seen_clr = 1'b1;
    p_exp = '0;
    p_mask = 16'hFFFF;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    idle();
    t_defaults();
    t_byte_write();
    t_samples();
    t_peak_clear();
    t_save_reload();
    t_selftest();
    final_report();
  end
endmodule : isr_register_access_tb

// >>> verification/isr_spi_master.sv
`timescale 1ns/1ns
module isr_spi_master
(
  output logic      o_sclk,   // Serial clock, idles high
  output logic      o_cs_n,   // Chip select
  output logic      o_din,    // Data to device
  input  wire logic i_dout,   // Data from device
  input  wire logic i_dout_oe // Device drive enable
);
  initial o_sclk = 1'b1;
  initial o_cs_n = 1'b1;
  initial o_din = 1'b0;
  // Sel low toggles the clock with select held high
  task automatic xfer(input logic [15:0] tx, input logic sel, output logic [15:0] rx);
    #1 o_cs_n = !sel;
    for (int i = 15; i >= 0; i--)
    begin
      #6 o_sclk = 1'b0;
      o_din = tx[i];
      #6 o_sclk = 1'b1;
      rx[i] = (i_dout_oe === 1'b1) ? i_dout : i[0];
    end
    #6 o_cs_n = 1'b1;
    o_din = !o_din;
    #40;
  endtask : xfer
endmodule : isr_spi_master
